// ==== dv/faceplate_model.sv ====
// Purpose: operand source standing in for pushbutton and relay logic
// Assumes: press_i and glitch_i come from the bench on the system clock
// Notes: unselected operands toggle each cycle so a wrong select shows up
`timescale 1ns/1ps
module faceplate_model
	import lamp_check_pkg::*;
#(
	parameter int SEL = 3,
	parameter int MIN_CYC = 260
)
(
	// clock
	input wire logic clk_sys_i,
	// bench commands
	input wire logic press_i,
	input wire logic glitch_i,
	// operand bus
	output logic [OPND_COUNT-1:0] operand_o
);
	logic [15:0] hold_r = 16'h0000;
	logic noise_r = 1'b0;

	// stretch every press by MIN_CYC cycles past its release unless a glitch is ordered
	always_ff @(posedge clk_sys_i)
	begin
		noise_r <= ~noise_r;
		if (press_i)
			hold_r <= 16'(MIN_CYC);
		else if (hold_r != 16'h0000)
			hold_r <= hold_r - 16'h0001;
	end

	// selected operand carries the press, the rest carry noise
	always_comb
	begin
		operand_o = {OPND_COUNT{noise_r}};
		operand_o[SEL] = glitch_i ? press_i : (press_i || hold_r != 16'h0000);
	end
endmodule

// ==== dv/indicator_lamp_test_sequencer_tb.sv ====
// Purpose: self-checking bench of the lamp self-test sequencer
// Assumes: one millisecond tick per clock, so 250/1000 ticks are cycles
// Notes: the one-minute stage one limit is not exercised here
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module indicator_lamp_test_sequencer_tb;
	import lamp_check_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [31:0] wr_data_i = '0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [31:0] rd_data_o;
	logic [OPND_COUNT-1:0] operand_i;
	logic reset_button_i = 1'b0;
	logic [LAMP_COUNT-1:0] lamp_req_i = 62'h0000000000000005;
	logic [LAMP_COUNT-1:0] lamp_o;
	logic target_reset_o;
	logic lamp_check_active_flag_o;
	logic lamp_check_started_event_o;
	logic irq_o;
	logic press = 1'b0;
	logic glitch = 1'b0;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	int ev_count = 0;
	int n;

	always #10 clk_sys_i = ~clk_sys_i;

	lamp_check_seq #(.MS_TICK_CYCLES(1)) lamp_check_seq_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.rd_data_o(rd_data_o), .operand_i(operand_i), .reset_button_i(reset_button_i),
		.lamp_req_i(lamp_req_i), .lamp_o(lamp_o), .target_reset_o(target_reset_o),
		.lamp_check_active_flag_o(lamp_check_active_flag_o),
		.lamp_check_started_event_o(lamp_check_started_event_o), .irq_o(irq_o));

	faceplate_model #(.SEL(3), .MIN_CYC(260)) faceplate_model_inst (
		.clk_sys_i(clk_sys_i), .press_i(press), .glitch_i(glitch), .operand_o(operand_i));

	// count start pulses and cut a hang short
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (lamp_check_started_event_o === 1'b1)
			ev_count++;
		if (cyc == 90000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_sys_i);
		wr_en_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_en_i <= 1'b0;
		#1;
		`CHK(rd_data_o, e)
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask

	// bounded wait for a lamp pattern, n returns one less than the cycles spent
	task automatic wait_lamp(input logic [LAMP_COUNT-1:0] e, input int lim);
		for (n = 0; n < lim; n++)
		begin
			@(posedge clk_sys_i);
			#1;
			if (lamp_o === e)
				break;
		end
		`CHK(lamp_o, e)
	endtask

	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(REG_CTRL, 32'h00000000);
		rd(REG_INT_MASK, 32'h00000000);
		rd(REG_INT_ST, 32'h00000000);
		rd(8'h10, 32'h00000000);
		// disabled: press ignored, lamps pass through
		@(posedge clk_sys_i) press <= 1'b1;
		@(posedge clk_sys_i) reset_button_i <= 1'b1;
		cycles(5);
		`CHK(target_reset_o, 1'b1)
		@(posedge clk_sys_i) reset_button_i <= 1'b0;
		cycles(400);
		@(posedge clk_sys_i) press <= 1'b0;
		cycles(600);
		`CHK(lamp_check_active_flag_o, 1'b0)
		`CHK(ev_count, 0)
		`CHK(lamp_o, lamp_req_i)
		wr(REG_CTRL, 32'h00000301);
		wr(REG_INT_MASK, 32'h00000003);
		rd(REG_CTRL, 32'h00000301);
		// a pulse shorter than the filter is invisible
		@(posedge clk_sys_i)
		begin
			glitch <= 1'b1;
			press <= 1'b1;
		end
		cycles(100);
		@(posedge clk_sys_i) press <= 1'b0;
		cycles(400);
		@(posedge clk_sys_i) glitch <= 1'b0;
		`CHK(ev_count, 0)
		// held press starts stage one
		@(posedge clk_sys_i) press <= 1'b1;
		wait_lamp({LAMP_COUNT{1'b1}}, 400);
		`CHK(ev_count, 1)
		`CHK(lamp_check_active_flag_o, 1'b1)
		`CHK(irq_o, 1'b1)
		@(posedge clk_sys_i)
		begin
			reset_button_i <= 1'b1;
			lamp_req_i <= 62'h2AAAAAAAAAAAAAAA;
		end
		cycles(300);
		`CHK(lamp_o, {LAMP_COUNT{1'b1}})
		`CHK(target_reset_o, 1'b0)
		rd(REG_STATE, 32'h00010011);
		@(posedge clk_sys_i) reset_button_i <= 1'b0;
		wr(REG_INT_ST, 32'h00000001);
		cycles(3);
		`CHK(irq_o, 1'b0)
		// release walks one lit lamp, one second each
		@(posedge clk_sys_i) press <= 1'b0;
		wait_lamp(62'h0000000000000001, 700);
		wait_lamp(62'h0000000000000002, 1100);
		`CHK((n >= 997 && n <= 1001), 1'b1)
		wait_lamp(62'h0000000000000004, 1100);
		rd(REG_STATE, 32'h00000213);
		`CHK(lamp_check_active_flag_o, 1'b1)
		// stage three follows on its own, one dark lamp at a time
		wait_lamp(~62'h0000000000000001, 61000);
		wait_lamp(~62'h0000000000000002, 1100);
		`CHK((n >= 997 && n <= 1001), 1'b1)
		// new press aborts and restores the tracked requests
		@(posedge clk_sys_i) press <= 1'b1;
		wait_lamp(62'h2AAAAAAAAAAAAAAA, 400);
		cycles(2);
		`CHK(lamp_check_active_flag_o, 1'b0)
		`CHK(irq_o, 1'b0)
		rd(REG_INT_ST, 32'h00000004);
		@(posedge clk_sys_i) press <= 1'b0;
		cycles(600);
		`CHK(ev_count, 1)
		tally_and_finish();
	end
endmodule

// ==== verilog/lamp_check_pkg.sv ====
// Purpose: shared constants and types of the lamp self-test sequencer
// Assumes: 50 MHz system clock, one synchronous active-low reset
// Notes: lamp index equals position in the walking order
package lamp_check_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// intervals in milliseconds, derived from printed units
	localparam int FILTER_MS = 250;
	localparam int STEP_S = 1;
	localparam int STEP_MS = STEP_S * 1000;
	localparam int STAGE1_MAX_MIN = 1;
	localparam int STAGE1_MAX_MS = STAGE1_MAX_MIN * 60000;
	// sizes
	localparam int LAMP_COUNT = 62;
	localparam int OPND_COUNT = 64;
	localparam int SEL_W = 6;
	localparam int IDX_W = 6;
	localparam int MS_W = 16;
	localparam int ADDR_W = 8;
	localparam int INT_W = 3;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_INT_ST = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0C;
	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 8;
	localparam int STATE_STAGE_LSB = 0;
	localparam int STATE_ACTIVE_BIT = 4;
	localparam int STATE_IDX_LSB = 8;
	localparam int STATE_FILT_BIT = 16;
	localparam int INT_START_BIT = 0;
	localparam int INT_DONE_BIT = 1;
	localparam int INT_ABORT_BIT = 2;
	// reset values
	localparam logic CTRL_EN_RST = 1'h0;
	localparam logic [5:0] CTRL_SEL_RST = 6'h00;
	localparam logic [2:0] INT_MASK_RST = 3'h0;
	// sequencer stages, gray along idle-1-2-3
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STAGE1 = 2'b01,
		ST_STAGE2 = 2'b11,
		ST_STAGE3 = 2'b10
	} stage_t;
endpackage

// ==== verilog/lamp_check_seq.sv ====
// Purpose: indicator lamp self-test sequencer with register port
// Assumes: operands and reset button arrive asynchronous to clk_sys_i
// Notes: lamp requests come from logic on the same clock
// Operation
// - enabled test starts from selected operand
// - pattern covers every lamp incl. pushbutton lamps
// - stage one lights all 62 lamps
// - stage one while held, ends after a minute
// - release in stage one enters stage two
// - stage two walks one lit lamp, 1 s
// - walk order column by column, top down
// - stage three follows stage two automatically
// - stage three walks one dark lamp, 1 s
// - new press aborts stage two or three
// - react to both level and rising edge
// - control pulses under 250 ms ignored
// - track requested states, restore them afterward
// - block target reset during the test
// - in-progress flag high for whole test
// - post started event when test begins
`timescale 1ns/1ps
module lamp_check_seq
	import lamp_check_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [31:0] rd_data_o,
	// operands and faceplate inputs
	input wire logic [OPND_COUNT-1:0] operand_i,
	input wire logic reset_button_i,
	input wire logic [LAMP_COUNT-1:0] lamp_req_i,
	// lamp drive and status outputs
	output logic [LAMP_COUNT-1:0] lamp_o,
	output logic target_reset_o,
	output logic lamp_check_active_flag_o,
	output logic lamp_check_started_event_o,
	output logic irq_o
);

	// single lamp in walking position idx
	function automatic logic [LAMP_COUNT-1:0] lamp_onehot(input logic [IDX_W-1:0] idx);
		logic [LAMP_COUNT-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction

	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(LAMP_COUNT - 1);
	localparam logic [MS_W-1:0] FILT_END = MS_W'(FILTER_MS - 1);
	localparam logic [MS_W-1:0] STEP_END = MS_W'(STEP_MS - 1);
	localparam logic [MS_W-1:0] S1_END = MS_W'(STAGE1_MAX_MS - 1);

	logic lamp_check_enable_r;
	logic [SEL_W-1:0] lamp_check_trigger_select_r;
	logic [INT_W-1:0] int_st_r;
	logic [INT_W-1:0] int_mask_r;
	logic [OPND_COUNT-1:0] opnd_s1_r;
	logic [OPND_COUNT-1:0] opnd_s2_r;
	logic rst_btn_s1_r;
	logic rst_btn_s2_r;
	logic [31:0] tick_cnt_r;
	logic tick_r;
	logic ctl_lvl;
	logic [MS_W-1:0] flt_cnt_r;
	logic filt_r;
	logic filt_d_r;
	logic rise;
	stage_t state_r;
	logic [IDX_W-1:0] idx_r;
	logic [MS_W-1:0] ms_cnt_r;
	logic [LAMP_COUNT-1:0] lamp_mem_r;
	logic [LAMP_COUNT-1:0] pattern;
	logic ev_start;
	logic ev_done;
	logic ev_abort;
	logic [INT_W-1:0] ev_vec;
	logic wr_ctrl;
	logic wr_clr;
	logic wr_mask;

	// two-flop synchronisers for outside inputs
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			opnd_s1_r <= '0;
			opnd_s2_r <= '0;
			rst_btn_s1_r <= 1'b0;
			rst_btn_s2_r <= 1'b0;
		end
		else
		begin
			opnd_s1_r <= operand_i;
			opnd_s2_r <= opnd_s1_r;
			rst_btn_s1_r <= reset_button_i;
			rst_btn_s2_r <= rst_btn_s1_r;
		end
	end

	// operand selection after the synchroniser
	assign ctl_lvl = opnd_s2_r[lamp_check_trigger_select_r];

	// millisecond tick, the only time base of the block
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else if (tick_cnt_r == 32'(MS_TICK_CYCLES - 1))
		begin
			tick_cnt_r <= '0;
			tick_r <= 1'b1;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
			tick_r <= 1'b0;
		end
	end

	// level filter: a change must stand 250 ms before it is believed;
	// granularity is one tick, so the real figure is 249 to 250 ms
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			flt_cnt_r <= '0;
			filt_r <= 1'b0;
			filt_d_r <= 1'b0;
		end
		else
		begin
			filt_d_r <= filt_r;
			if (ctl_lvl == filt_r)
				flt_cnt_r <= '0;
			else if (tick_r)
			begin
				if (flt_cnt_r == FILT_END)
				begin
					filt_r <= ctl_lvl;
					flt_cnt_r <= '0;
				end
				else
					flt_cnt_r <= flt_cnt_r + MS_W'(1);
			end
		end
	end

	// qualified press edge, used beside the level
	assign rise = filt_r & ~filt_d_r;

	// sequencer events
	always_comb
	begin
		ev_start = lamp_check_enable_r && state_r == ST_IDLE && rise;
		ev_done = 1'b0;
		ev_abort = 1'b0;
		if (!lamp_check_enable_r)
			ev_abort = state_r != ST_IDLE;
		else if (state_r == ST_STAGE1)
			ev_done = filt_r && tick_r && ms_cnt_r == S1_END;
		else if (state_r == ST_STAGE2 || state_r == ST_STAGE3)
		begin
			ev_abort = rise;
			ev_done = !rise && state_r == ST_STAGE3 && tick_r &&
				ms_cnt_r == STEP_END && idx_r == IDX_LAST;
		end
	end

	// stage sequencer, stage timer and walking index
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= ST_IDLE;
			idx_r <= '0;
			ms_cnt_r <= '0;
		end
		else if (!lamp_check_enable_r)
		begin
			state_r <= ST_IDLE;
			idx_r <= '0;
			ms_cnt_r <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					idx_r <= '0;
					ms_cnt_r <= '0;
					if (rise)
						state_r <= ST_STAGE1;
				end
				ST_STAGE1:
				begin
					if (!filt_r)
					begin
						state_r <= ST_STAGE2;
						idx_r <= '0;
						ms_cnt_r <= '0;
					end
					else if (tick_r)
					begin
						if (ms_cnt_r == S1_END)
							state_r <= ST_IDLE;
						else
							ms_cnt_r <= ms_cnt_r + MS_W'(1);
					end
				end
				ST_STAGE2, ST_STAGE3:
				begin
					if (rise)
					begin
						state_r <= ST_IDLE;
						idx_r <= '0;
						ms_cnt_r <= '0;
					end
					else if (tick_r)
					begin
						if (ms_cnt_r == STEP_END)
						begin
							ms_cnt_r <= '0;
							if (idx_r == IDX_LAST)
							begin
								idx_r <= '0;
								state_r <= (state_r == ST_STAGE2) ? ST_STAGE3 : ST_IDLE;
							end
							else
								idx_r <= idx_r + IDX_W'(1);
						end
						else
							ms_cnt_r <= ms_cnt_r + MS_W'(1);
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
					idx_r <= '0;
					ms_cnt_r <= '0;
				end
			endcase
		end
	end

	// test pattern for every lamp, pushbutton lamps included
	always_comb
	begin
		case (state_r)
			ST_STAGE1: pattern = '1;
			ST_STAGE2: pattern = lamp_onehot(idx_r);
			ST_STAGE3: pattern = ~lamp_onehot(idx_r);
			default: pattern = lamp_mem_r;
		endcase
	end

	// requested states are recorded in every cycle, test or not,
	// so the lamps come back to the live picture when the test ends
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			lamp_mem_r <= '0;
			lamp_o <= '0;
		end
		else
		begin
			lamp_mem_r <= lamp_req_i;
			lamp_o <= pattern;
		end
	end

	// flag, event pulse and gated target reset
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			lamp_check_active_flag_o <= 1'b0;
			lamp_check_started_event_o <= 1'b0;
			target_reset_o <= 1'b0;
		end
		else
		begin
			lamp_check_active_flag_o <= state_r != ST_IDLE;
			lamp_check_started_event_o <= ev_start;
			target_reset_o <= rst_btn_s2_r && state_r == ST_IDLE;
		end
	end

	// register write decode
	assign wr_ctrl = wr_en_i && addr_i == REG_CTRL;
	assign wr_clr = wr_en_i && addr_i == REG_INT_ST;
	assign wr_mask = wr_en_i && addr_i == REG_INT_MASK;

	// control and mask registers
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			lamp_check_enable_r <= CTRL_EN_RST;
			lamp_check_trigger_select_r <= CTRL_SEL_RST;
			int_mask_r <= INT_MASK_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				lamp_check_enable_r <= wr_data_i[CTRL_EN_BIT];
				lamp_check_trigger_select_r <= wr_data_i[CTRL_SEL_LSB +: SEL_W];
			end
			if (wr_mask)
				int_mask_r <= wr_data_i[INT_W-1:0];
		end
	end

	// sticky status, write one clears; a same-cycle event wins
	assign ev_vec = {ev_abort, ev_done, ev_start};
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			int_st_r <= '0;
		else if (wr_clr)
			int_st_r <= (int_st_r & ~wr_data_i[INT_W-1:0]) | ev_vec;
		else
			int_st_r <= int_st_r | ev_vec;
	end

	// level interrupt from the registered status
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(int_st_r & int_mask_r);
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			rd_data_o <= '0;
		else
		begin
			rd_data_o <= '0;
			if (rd_en_i)
			begin
				case (addr_i)
					REG_CTRL:
					begin
						rd_data_o[CTRL_EN_BIT] <= lamp_check_enable_r;
						rd_data_o[CTRL_SEL_LSB +: SEL_W] <= lamp_check_trigger_select_r;
					end
					REG_STATE:
					begin
						rd_data_o[STATE_STAGE_LSB +: 2] <= state_r;
						rd_data_o[STATE_ACTIVE_BIT] <= state_r != ST_IDLE;
						rd_data_o[STATE_IDX_LSB +: IDX_W] <= idx_r;
						rd_data_o[STATE_FILT_BIT] <= filt_r;
					end
					REG_INT_ST: rd_data_o[INT_W-1:0] <= int_st_r;
					REG_INT_MASK: rd_data_o[INT_W-1:0] <= int_mask_r;
					default: rd_data_o <= '0;
				endcase
			end
		end
	end

	// checks on the sequencer
	AST_START_EVENT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_IDLE && lamp_check_enable_r && rise) |=>
		(lamp_check_started_event_o && state_r == ST_STAGE1))
		else $error("start did not post event");

	AST_STAGE1_ALL_ON: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_STAGE1) |=> (lamp_o == {LAMP_COUNT{1'b1}}))
		else $error("stage one lamps not all lit");

	AST_STAGE1_TIMEOUT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_STAGE1 && lamp_check_enable_r && filt_r && tick_r &&
		ms_cnt_r == S1_END) |=> (state_r == ST_IDLE))
		else $error("stage one did not end at one minute");

	AST_RELEASE_TO_S2: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_STAGE1 && lamp_check_enable_r && !filt_r) |=>
		(state_r == ST_STAGE2 && idx_r == '0) ##1 (lamp_o == lamp_onehot('0)))
		else $error("release did not enter stage two");

	AST_ABORT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		((state_r == ST_STAGE2 || state_r == ST_STAGE3) && rise) |=>
		(state_r == ST_IDLE) ##1 !lamp_check_active_flag_o)
		else $error("press did not abort the walk");

	AST_WALK_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		((state_r == ST_STAGE2 || state_r == ST_STAGE3) && lamp_check_enable_r &&
		!rise && tick_r && ms_cnt_r == STEP_END && idx_r != IDX_LAST) |=>
		(idx_r == $past(idx_r) + IDX_W'(1) && ms_cnt_r == '0))
		else $error("walk step wrong");

	AST_S2_TO_S3: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_STAGE2 && lamp_check_enable_r && !rise && tick_r &&
		ms_cnt_r == STEP_END && idx_r == IDX_LAST) |=>
		(state_r == ST_STAGE3) ##1 (lamp_o == ~lamp_onehot('0)))
		else $error("stage three did not follow");

	AST_FLAG_TRACKS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		##1 (lamp_check_active_flag_o == ($past(state_r) != ST_IDLE)))
		else $error("in-progress flag wrong");

	AST_TARGET_BLOCK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		lamp_check_active_flag_o |-> !target_reset_o)
		else $error("target reset during test");

	// the record needs one clean edge after reset before it mirrors the requests
	AST_RESTORE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_IDLE && $past(state_r) == ST_IDLE && $past(rst_n_i)) |=>
		(lamp_o == $past(lamp_req_i, 2)))
		else $error("lamps not showing requested states");

	AST_FILTER: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(filt_r) |-> ($past(flt_cnt_r) == FILT_END && $past(tick_r)))
		else $error("filter changed before 250 ms");

	AST_DISABLED: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!lamp_check_enable_r ##1 !lamp_check_enable_r) |=> !lamp_check_active_flag_o)
		else $error("flag high while disabled");

	// a one-cycle divider ticks on every edge, any longer one never twice in a row
	AST_TICK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tick_r |=> (tick_r == (MS_TICK_CYCLES == 1)))
		else $error("tick longer than one cycle");

endmodule
